// file: nhr_host_answer_regs.sv
// module: host answer register group of a pass-through tag, with request handshake
`timescale 1ns/100ps
`default_nettype none

// What this block does
// R1: host clears interrupt flag just before answering
// R2: answer bits 15..4 reserved, kept zero
// R3: extra-data flag only while prefetch pending
// R4: prefetch request only when extra-data enabled
// R5: extra-data flag makes device update buffer size
// R6: custom select low gives default status word
// R7: custom select high uses custom status word
// R8: file-exists bit carries host's file verdict
// R9: host sets serviced after full servicing
// R10: device waits for serviced, then processes answer
// R11: block length presented as 16-bit value
// R12: block length high byte 15..8, low 7..0
// R13: file offset 16-bit, upper byte higher address
// R14: file identifier from select, first byte low
// R15: response, length, offset registers reset zero
module nhr_host_answer_regs
  import nhr_pkg::*;
(
  input  wire logic        clk_i,           // system clock, 25 MHz
  input  wire logic        rst_i,           // synchronous reset, high
  input  wire logic        wb_cyc_i,        // wishbone cycle
  input  wire logic        wb_stb_i,        // wishbone strobe
  input  wire logic        wb_we_i,         // wishbone write enable
  input  wire logic [17:0] wb_adr_i,        // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,        // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,        // wishbone write data
  output logic      [31:0] wb_dat_o,        // wishbone read data
  output logic             wb_ack_o,        // wishbone acknowledge
  output logic             irq_o,           // interrupt to the host, high
  input  wire logic        cmd_valid_i,     // reader command offered
  input  wire nhr_cmd_t    cmd_i,           // reader command contents
  output logic             cmd_ready_o,     // command can be taken
  input  wire logic        read_tx_i,       // read answer transmission starts
  input  wire logic [15:0] custom_sw_i,     // custom status word value
  output logic             resp_valid_o,    // answer to reader ready, pulse
  output nhr_answer_t      resp_o,          // answer to reader
  output logic             buffer_update_o  // extra data added, pulse
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_HOST,
    ST_ANSWER
  } nhr_state_t;

  nhr_state_t             state;
  nhr_state_t             next_state;
  nhr_wb_req_t            req;
  logic                   acc;
  logic                   wr;
  logic [31:0]            rd_data;
  logic [15:0]            file_offset;
  logic [15:0]            block_length;
  logic [HA_USED_W-1:0]   host_answer;
  logic [15:0]            file_id;
  logic                   ctrl_extra_en;
  logic [IRQ_W-1:0]       irq_status;
  logic [IRQ_W-1:0]       irq_mask;
  logic [IRQ_W-1:0]       irq_event;
  logic                   last_was_read;
  logic                   prefetch_pending;
  logic                   take_cmd;
  logic                   done;
  logic                   extra_seen;
  logic                   hit_offset;
  logic                   hit_length;
  logic                   hit_answer;
  logic                   hit_fid;
  logic                   hit_ctrl;
  logic                   hit_stat;
  logic                   hit_mask;
  logic [15:0]            next_file_offset;
  logic [15:0]            next_block_length;
  logic [15:0]            next_file_id;
  logic [HA_USED_W-1:0]   next_host_answer;
  logic [HA_USED_W-1:0]   hw_clear;
  logic                   wr_offset;
  logic                   wr_length;
  logic                   wr_fid;
  logic                   wr_answer;
  logic                   wr_ctrl;
  logic                   take_rw;
  logic                   take_sel;

  // byte-lane merge of a 16-bit register: lane 0 is bits 7..0, lane 1 bits 15..8
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
  endfunction

  // ==========================================================================
  // bus front end and interrupt block
  // ==========================================================================
  nhr_wb_port u_port (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cyc_i     (wb_cyc_i),
    .stb_i     (wb_stb_i),
    .we_i      (wb_we_i),
    .adr_i     (wb_adr_i),
    .sel_i     (wb_sel_i),
    .dat_i     (wb_dat_i),
    .rd_data_i (rd_data),
    .acc_o     (acc),
    .req_o     (req),
    .ack_o     (wb_ack_o),
    .dat_o     (wb_dat_o)
  );

  // status and mask are two-bit fields, so only the low lane writes them
  nhr_irq u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .event_i   (irq_event),
    .wr_stat_i (wr && hit_stat && req.sel[0]),
    .wr_mask_i (wr && hit_mask && req.sel[0]),
    .wdata_i   (req.dat[IRQ_W-1:0]),
    .status_o  (irq_status),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  // ==========================================================================
  // address decode
  // ==========================================================================
  // unmapped indices still get ack, read as zero and ignore writes
  assign wr         = acc & req.we;
  assign hit_offset = (req.idx == IDX_FILE_OFFSET);
  assign hit_length = (req.idx == IDX_BLOCK_LENGTH);
  assign hit_answer = (req.idx == IDX_HOST_ANSWER);
  assign hit_fid    = (req.idx == IDX_FILE_ID);
  assign hit_ctrl   = (req.idx == IDX_CTRL);
  assign hit_stat   = (req.idx == IDX_IRQ_STATUS);
  assign hit_mask   = (req.idx == IDX_IRQ_MASK);

  // per-register write strobes; narrow registers take the low lane only
  // a write lands at the edge that takes the request, the same edge that raises ack
  assign wr_offset  = wr & hit_offset;
  assign wr_length  = wr & hit_length;
  assign wr_fid     = wr & hit_fid;
  assign wr_answer  = wr & hit_answer & req.sel[0];
  assign wr_ctrl    = wr & hit_ctrl & req.sel[0];

  // reads have no side effects, so polling the answer register is safe
  // read mux; bits above each register's width read as zero
  assign rd_data =
      hit_offset ? {16'h0000, file_offset} :                           // [R13]
      hit_length ? {16'h0000, block_length[15:8], block_length[7:0]} : // [R11] [R12]
      hit_answer ? {28'h000_0000, host_answer} :                       // [R2]
      hit_fid    ? {16'h0000, file_id} :                               // [R14]
      hit_ctrl   ? {31'h0000_0000, ctrl_extra_en} :
      hit_stat   ? {30'h0000_0000, irq_status} :
      hit_mask   ? {30'h0000_0000, irq_mask} :
                   32'h0000_0000;

  // ==========================================================================
  // request handshake with the host
  // ==========================================================================
  // one command is held at a time; the reader side waits on cmd_ready_o
  assign take_cmd = cmd_valid_i & cmd_ready_o;
  // read and update publish length and offset; select publishes the file id
  assign take_rw  = take_cmd & (cmd_i.kind != CMD_SELECT);
  assign take_sel = take_cmd & (cmd_i.kind == CMD_SELECT);
  // nothing proceeds until the host has flagged the request serviced
  assign done = (state == ST_WAIT_HOST) && host_answer[HA_SERVICED];  // [R10] [R9]

  // three states: idle, waiting on the host, one cycle of answer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take_cmd) begin
          next_state = ST_WAIT_HOST;
        end
      end
      ST_WAIT_HOST: begin
        if (done) begin
          next_state = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // the host is expected to clear the request flag and then write the answer
  // one flag is enough: the reader holds its next command until idle
  assign irq_event[IRQ_REQUEST]  = take_cmd;                          // [R1]
  // prefetch request only after a read and only with the feature enabled
  assign irq_event[IRQ_PREFETCH] = read_tx_i & last_was_read & ctrl_extra_en; // [R4]
  // extra-data flag is honoured only while a prefetch request stands
  assign extra_seen = prefetch_pending & host_answer[HA_EXTRA_DATA];  // [R3] [R5]

  // ==========================================================================
  // register next values
  // ==========================================================================
  // the tag records length and offset of read and update commands;
  // a command beats a same-cycle host write, since the reader owns them
  assign next_block_length =
      take_rw   ? cmd_i.length :                                 // [R11]
      wr_length ? merge16(block_length, req.dat, req.sel) :      // [R12]
      block_length;

  assign next_file_offset =
      take_rw   ? cmd_i.offset :                                 // [R13]
      wr_offset ? merge16(file_offset, req.dat, req.sel) :
      file_offset;

  assign next_file_id =
      take_sel ? cmd_i.file_id :                                 // [R14]
      wr_fid   ? merge16(file_id, req.dat, req.sel) :
      file_id;

  // hardware consumes serviced and extra-data flags; a host write the same
  // cycle wins, so a freshly written answer is never lost
  assign hw_clear = {extra_seen, 2'b00, done};
  assign next_host_answer =
      wr_answer ? req.dat[HA_USED_W-1:0] :                       // [R2]
      (host_answer & ~hw_clear);

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_offset  <= RST_WORD;                                         // [R15]
      block_length <= RST_WORD;                                         // [R15]
      host_answer  <= RST_ANSWER;                                       // [R15]
      file_id      <= RST_WORD;
    end else begin
      file_offset  <= next_file_offset;
      block_length <= next_block_length;
      host_answer  <= next_host_answer;
      file_id      <= next_file_id;
    end
  end

  // control bit; a one-bit register, so only the low lane writes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_extra_en <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_extra_en <= req.dat[CTRL_EXTRA_EN];
    end
  end

  // prefetch tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_was_read    <= 1'b0;
      prefetch_pending <= 1'b0;
    end else begin
      if (take_cmd) begin
        last_was_read <= (cmd_i.kind == CMD_READ);
      end
      // a new request from the reader ends any open prefetch window
      if (irq_event[IRQ_PREFETCH]) begin
        prefetch_pending <= 1'b1;
      end else if (extra_seen || take_cmd) begin
        prefetch_pending <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // state and outputs toward the reader side
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state           <= ST_IDLE;
      cmd_ready_o     <= 1'b0;
      resp_valid_o    <= 1'b0;
      buffer_update_o <= 1'b0;
    end else begin
      state           <= next_state;
      cmd_ready_o     <= (next_state == ST_IDLE);
      resp_valid_o    <= done;
      buffer_update_o <= extra_seen;                                   // [R5]
    end
  end

  // answer fields change only when the host is done and then stand
  // unchanged for the reader until the next answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_o <= '0;
    end else if (done) begin
      // status word chosen at the moment the answer is processed
      resp_o.status_word <= host_answer[HA_CUSTOM_SW] ? custom_sw_i  // [R7]
                                                      : SW_DEFAULT;  // [R6]
      resp_o.file_exists <= host_answer[HA_FILE_EXISTS];             // [R8]
    end
  end

endmodule
`default_nettype wire

// file: nhr_host_answer_regs_bench.sv
// testbench: host side over wishbone against the host answer register block
`timescale 1ns/100ps
`default_nettype none
module nhr_host_answer_regs_bench;
  import nhr_pkg::*;
  // ==========================================================================
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [17:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat_w = '0, dat_r, rd;
  logic        ack, irq, cmd_valid, cmd_ready, read_tx, resp_valid, buf_upd;
  logic [15:0] csw;
  nhr_cmd_t    cmd;
  nhr_answer_t resp, resp_seen;
  int          error_cnt = 0, comparisons = 0, resp_cnt = 0, buf_cnt = 0;

  always #20 clk_i = ~clk_i;

  nhr_host_answer_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .irq_o(irq), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready),
    .read_tx_i(read_tx), .custom_sw_i(csw), .resp_valid_o(resp_valid), .resp_o(resp),
    .buffer_update_o(buf_upd));
  nhr_rf_model rf_u (.clk_i(clk_i), .cmd_ready_i(cmd_ready), .cmd_o(cmd),
    .cmd_valid_o(cmd_valid), .read_tx_o(read_tx), .custom_sw_o(csw));

  // pulses are counted from pre-edge values so no race with the design
  always @(posedge clk_i) begin
    if (resp_valid === 1'b1) begin
      resp_cnt++;
      resp_seen = resp;
    end
    if (buf_upd === 1'b1) buf_cnt++;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // classic single cycle; waits for ack, the watchdog bounds the wait
  task automatic wb_cycle(input logic w, input logic [15:0] idx, input logic [3:0] s,
                          input logic [31:0] d);
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {idx, 2'b00};
    sel   <= s;
    dat_w <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    wb_cycle(1'b1, idx, 4'h3, d);
  endtask

  task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
    wb_cycle(1'b0, idx, 4'h3, 32'h0);
    check(name, rd, exp);
  endtask

  // host answers a request: flag cleared just before the answer goes in
  task automatic service(input logic [31:0] ans, input logic [15:0] sw, input logic ex);
    int n;
    n = resp_cnt;
    wr(IDX_IRQ_STATUS, 32'h1);
    wr(IDX_HOST_ANSWER, ans);
    repeat (3) @(posedge clk_i);
    check("answer count", resp_cnt - n, 1);
    check("status word", {16'h0, resp_seen.status_word}, {16'h0, sw});
    check("file exists", {31'h0, resp_seen.file_exists}, {31'h0, ex});
  endtask

  task automatic t_reset();
    rd_chk("offset rst", IDX_FILE_OFFSET, 32'h0);
    rd_chk("length rst", IDX_BLOCK_LENGTH, 32'h0);
    rd_chk("answer rst", IDX_HOST_ANSWER, 32'h0);
    check("irq rst", {31'h0, irq}, 32'h0);
    wb_cycle(1'b1, IDX_FILE_OFFSET, 4'h1, 32'hA5C3);
    rd_chk("low lane only", IDX_FILE_OFFSET, 32'h00C3);
    wr(16'h0100, 32'hFFFF);
    rd_chk("unmapped", 16'h0100, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_read();
    wr(IDX_IRQ_MASK, 32'h3);
    rf_u.send(CMD_READ, 16'h0, 16'h1234, 16'hABCD);
    repeat (2) @(posedge clk_i);
    check("irq on request", {31'h0, irq}, 32'h1);
    rd_chk("block length", IDX_BLOCK_LENGTH, 32'hABCD);
    rd_chk("file offset", IDX_FILE_OFFSET, 32'h1234);
    service(32'h1, SW_DEFAULT, 1'b0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk("serviced consumed", IDX_HOST_ANSWER, 32'h0);
    $display("test read done");
  endtask

  task automatic t_select();
    rf_u.send(CMD_SELECT, 16'h03E1, 16'h0, 16'h0);
    repeat (2) @(posedge clk_i);
    rd_chk("file id", IDX_FILE_ID, 32'h03E1);
    service(32'h7, 16'h6A82, 1'b1);
    rd_chk("flags kept", IDX_HOST_ANSWER, 32'h6);
    $display("test select done");
  endtask

  task automatic t_prefetch();
    int n;
    wr(IDX_CTRL, 32'h0);
    rf_u.send(CMD_READ, 16'h0, 16'h0010, 16'h0020);
    service(32'h1, SW_DEFAULT, 1'b0);
    rf_u.tx_start();
    rd_chk("no prefetch off", IDX_IRQ_STATUS, 32'h0);
    wr(IDX_CTRL, 32'h1);
    rf_u.send(CMD_READ, 16'h0, 16'h0030, 16'h0040);
    service(32'h1, SW_DEFAULT, 1'b0);
    rf_u.tx_start();
    rd_chk("prefetch on", IDX_IRQ_STATUS, 32'h2);
    wr(IDX_IRQ_STATUS, 32'h2);
    n = buf_cnt;
    wr(IDX_HOST_ANSWER, 32'h8);
    repeat (3) @(posedge clk_i);
    check("buffer update", buf_cnt - n, 1);
    rd_chk("extra consumed", IDX_HOST_ANSWER, 32'h0);
    rf_u.send(CMD_UPDATE, 16'h0, 16'h0050, 16'h0060);
    service(32'h1, SW_DEFAULT, 1'b0);
    rf_u.tx_start();
    rd_chk("no prefetch after update", IDX_IRQ_STATUS, 32'h0);
    rd_chk("update length", IDX_BLOCK_LENGTH, 32'h0060);
    $display("test prefetch done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_read();
    t_select();
    t_prefetch();
    conclude();
  end
endmodule
`default_nettype wire

// file: nhr_host_answer_regs_sva.sv
// checker: port timing of the host answer register block
`timescale 1ns/100ps
`default_nettype none
module nhr_host_answer_regs_sva
  import nhr_pkg::*;
(
  input wire logic        clk_i,          // clock
  input wire logic        rst_i,          // reset
  input wire logic        wb_cyc_i,       // cycle
  input wire logic        wb_stb_i,       // strobe
  input wire logic [31:0] wb_dat_o,       // read data
  input wire logic        wb_ack_o,       // acknowledge
  input wire logic        irq_o,          // interrupt
  input wire logic        cmd_valid_i,    // command offered
  input wire nhr_cmd_t    cmd_i,          // command
  input wire logic        cmd_ready_o,    // command ready
  input wire logic        read_tx_i,      // read answer starts
  input wire logic [15:0] custom_sw_i,    // custom status word
  input wire logic        resp_valid_o,   // answer pulse
  input wire nhr_answer_t resp_o,         // answer
  input wire logic        buffer_update_o // extra data pulse
);
  // ==========================================================================
  // helper: a buffer update can only follow a read answer going out
  logic last_read;
  logic tx_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_read <= 1'b0;
      tx_seen   <= 1'b0;
    end else begin
      if (cmd_valid_i && cmd_ready_o) begin
        last_read <= (cmd_i.kind == CMD_READ);
      end
      if (read_tx_i && last_read) begin
        tx_seen <= 1'b1;
      end else if (cmd_valid_i && cmd_ready_o) begin
        tx_seen <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus answers in exactly one cycle and only for one cycle
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow the request by one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_reset_clean: assert property ($past(rst_i) |-> !wb_ack_o && !irq_o && !resp_valid_o
    && !buffer_update_o && resp_o == '0)
    else $error("outputs not clear after reset");
  a_take_busy: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
    else $error("ready stayed high after a command was taken");
  a_answer_waits: assert property (resp_valid_o |-> !cmd_ready_o)
    else $error("answer given while no request was pending");
  a_answer_pulse: assert property (resp_valid_o |=> !resp_valid_o && cmd_ready_o)
    else $error("answer pulse too long or ready not back");
  a_sw_source: assert property (resp_valid_o |-> resp_o.status_word == SW_DEFAULT
    || resp_o.status_word == $past(custom_sw_i))
    else $error("status word from neither source");
  a_update_cause: assert property (buffer_update_o |-> $past(tx_seen))
    else $error("buffer update without a read answer going out");
endmodule
`default_nettype wire

bind nhr_host_answer_regs nhr_host_answer_regs_sva chk_u (.*);

// file: nhr_irq.sv
// module: sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/100ps
`default_nettype none
module nhr_irq
  import nhr_pkg::*;
(
  input  wire logic             clk_i,      // system clock
  input  wire logic             rst_i,      // synchronous reset, high
  input  wire logic [IRQ_W-1:0] event_i,    // event pulses
  input  wire logic             wr_stat_i,  // status write strobe
  input  wire logic             wr_mask_i,  // mask write strobe
  input  wire logic [IRQ_W-1:0] wdata_i,    // write data
  output logic      [IRQ_W-1:0] status_o,   // sticky status
  output logic      [IRQ_W-1:0] mask_o,     // enable mask
  output logic                  irq_o       // interrupt, high level
);

  logic [IRQ_W-1:0] next_status;
  logic [IRQ_W-1:0] next_mask;

  // ==========================================================================
  // next values
  // ==========================================================================
  // an event in the same cycle as its clear survives: set wins
  assign next_status = (status_o & ~(wr_stat_i ? wdata_i : RST_IRQ)) | event_i;
  assign next_mask   = wr_mask_i ? wdata_i : mask_o;

  // irq is taken from next values so it follows status with no extra cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= RST_IRQ;
      mask_o   <= RST_IRQ;
      irq_o    <= 1'b0;
    end else begin
      status_o <= next_status;
      mask_o   <= next_mask;
      irq_o    <= |(next_status & next_mask);
    end
  end

endmodule
`default_nettype wire

// file: nhr_pkg.sv
// package: register map, field layout, reset values and carrier types of the host answer block
package nhr_pkg;

  // ==========================================================================
  // register indices (byte address on the bus is four times the index)
  // ==========================================================================
  localparam int          IDX_W            = 16;
  localparam logic [15:0] IDX_FILE_OFFSET  = 16'hFFE6;
  localparam logic [15:0] IDX_BLOCK_LENGTH = 16'hFFE8;
  localparam logic [15:0] IDX_HOST_ANSWER  = 16'hFFEA;
  localparam logic [15:0] IDX_FILE_ID      = 16'hFFEC;
  localparam logic [15:0] IDX_CTRL         = 16'hFF80;
  localparam logic [15:0] IDX_IRQ_STATUS   = 16'hFF81;
  localparam logic [15:0] IDX_IRQ_MASK     = 16'hFF82;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int HA_SERVICED    = 0;
  localparam int HA_FILE_EXISTS = 1;
  localparam int HA_CUSTOM_SW   = 2;
  localparam int HA_EXTRA_DATA  = 3;
  localparam int HA_USED_W      = 4;
  localparam int CTRL_EXTRA_EN  = 0;
  localparam int IRQ_REQUEST    = 0;
  localparam int IRQ_PREFETCH   = 1;
  localparam int IRQ_W          = 2;

  // ==========================================================================
  // reset values and fixed answers
  // ==========================================================================
  localparam logic [15:0]          RST_WORD     = 16'h0000;
  localparam logic [HA_USED_W-1:0] RST_ANSWER   = 4'h0;
  localparam logic                 RST_CTRL     = 1'b0;
  localparam logic [IRQ_W-1:0]     RST_IRQ      = 2'h0;
  localparam logic [15:0]          SW_DEFAULT   = 16'h9000;

  // ==========================================================================
  // carrier types
  // ==========================================================================
  typedef enum logic [1:0] {
    CMD_SELECT,
    CMD_READ,
    CMD_UPDATE
  } nhr_cmd_kind_t;

  // one reader command as handed over by the RF engine
  typedef struct packed {
    nhr_cmd_kind_t kind;
    logic [15:0]   file_id;
    logic [15:0]   offset;
    logic [15:0]   length;
  } nhr_cmd_t;

  // answer returned to the RF engine once the host has serviced the request
  typedef struct packed {
    logic [15:0] status_word;
    logic        file_exists;
  } nhr_answer_t;

  // one accepted bus access
  typedef struct packed {
    logic             we;
    logic [IDX_W-1:0] idx;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } nhr_wb_req_t;

endpackage

// file: nhr_rf_model.sv
// partner model: the reader-side engine handing commands to the block
`timescale 1ns/100ps
`default_nettype none
module nhr_rf_model
  import nhr_pkg::*;
(
  input  wire logic   clk_i,       // clock
  input  wire logic   cmd_ready_i, // block can take a command
  output nhr_cmd_t    cmd_o,       // command contents
  output logic        cmd_valid_o, // command offered
  output logic        read_tx_o,   // read answer goes out, pulse
  output logic [15:0] custom_sw_o  // custom status word
);
  // ==========================================================================
  initial begin
    cmd_o       = '0;
    cmd_valid_o = 1'b0;
    read_tx_o   = 1'b0;
    custom_sw_o = 16'h6A82;
  end

  // offer one command and hold it until the edge that takes it
  task automatic send(input nhr_cmd_kind_t kind, input logic [15:0] fid, off, len);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o       <= '{kind, fid, off, len};
    do @(posedge clk_i); while (cmd_ready_i !== 1'b1);
    cmd_valid_o <= 1'b0;
    cmd_o       <= ~cmd_o; // stale contents scrambled so nothing leans on them
  endtask

  // one-cycle marker that a read answer starts on air
  task automatic tx_start();
    @(posedge clk_i);
    read_tx_o <= 1'b1;
    @(posedge clk_i);
    read_tx_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: nhr_wb_port.sv
// module: classic wishbone slave front end, one wait state, registered answer
`timescale 1ns/100ps
`default_nettype none
module nhr_wb_port
  import nhr_pkg::*;
(
  input  wire logic        clk_i,     // system clock
  input  wire logic        rst_i,     // synchronous reset, high
  input  wire logic        cyc_i,     // bus cycle
  input  wire logic        stb_i,     // strobe
  input  wire logic        we_i,      // write enable
  input  wire logic [17:0] adr_i,     // byte address
  input  wire logic [3:0]  sel_i,     // byte lanes
  input  wire logic [31:0] dat_i,     // write data
  input  wire logic [31:0] rd_data_i, // read data of the addressed register
  output logic             acc_o,     // access strobe, one cycle
  output nhr_wb_req_t      req_o,     // access contents
  output logic             ack_o,     // acknowledge
  output logic [31:0]      dat_o      // read data
);

  // ==========================================================================
  // decode
  // ==========================================================================
  // the cycle in which ack is high stays quiet so a held request is taken only once
  assign acc_o      = cyc_i & stb_i & ~ack_o;
  assign req_o.we   = we_i;
  assign req_o.idx  = adr_i[17:2];
  assign req_o.sel  = sel_i;
  assign req_o.dat  = dat_i;

  // ==========================================================================
  // answer
  // ==========================================================================
  // read data is captured with ack, so it is stable while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= acc_o;
      dat_o <= (acc_o && !we_i) ? rd_data_i : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire
